// ===== cgl_pkg.sv
/*
 * cgl_pkg: constants and types for the camera gpio line control block.
 * assumes a 100 MHz core clock and a plain byte-addressed register port.
 */
package cgl_pkg;
	localparam int unsigned CLK_MHZ = 100;
	localparam int unsigned CYC_PER_US = CLK_MHZ;
	localparam int unsigned LINES = 4;
	// register byte offsets
	localparam logic [7:0] REG_PIN_INDEX_PICK = 8'h00;
	localparam logic [7:0] REG_PIN_DIR = 8'h04;
	localparam logic [7:0] REG_PIN_POLARITY_FLIP = 8'h08;
	localparam logic [7:0] REG_PIN_LEVEL_NOW = 8'h0c;
	localparam logic [7:0] REG_LINE_LEVELS_SNAPSHOT = 8'h10;
	localparam logic [7:0] REG_PIN_FILTER_KIND_PICK = 8'h14;
	localparam logic [7:0] REG_PIN_FILTER_SPAN_US = 8'h18;
	localparam logic [7:0] REG_PIN_DRIVE_ORIGIN = 8'h1c;
	localparam logic [7:0] REG_SOFT_BIT_PICK = 8'h20;
	localparam logic [7:0] REG_SOFT_BIT_LEVEL = 8'h24;
	localparam logic [7:0] REG_USER_OUTPUT_WORD = 8'h28;
	localparam logic [7:0] REG_PIN_CIRCUIT_TYPE = 8'h2c;
	localparam logic [7:0] REG_AUX_RAIL_SWITCH = 8'h30;
	// field positions and widths
	localparam int unsigned SPAN_W = 16;
	localparam int unsigned CNT_W = 24;
	localparam int unsigned DIR_OUT_BIT = 0;
	// reset values
	localparam logic [31:0] RD_IDLE = 32'h0000_0000;
	// filter kinds
	localparam logic FILT_DEGLITCH = 1'b0;
	localparam logic FILT_DEBOUNCE = 1'b1;
	// circuit types reported per line
	localparam logic [1:0] FMT_TRI_STATE = 2'h0;
	localparam logic [1:0] FMT_OPTO = 2'h1;
	localparam logic [1:0] FMT_OPEN_DRAIN = 2'h2;

	// drive origin codes
	typedef enum logic [3:0] {
		SRC_LINE0 = 4'h0,
		SRC_LINE1 = 4'h1,
		SRC_LINE2 = 4'h2,
		SRC_LINE3 = 4'h3,
		SRC_USER0 = 4'h4,
		SRC_USER1 = 4'h5,
		SRC_USER2 = 4'h6,
		SRC_USER3 = 4'h7,
		SRC_CTR0 = 4'h8,
		SRC_CTR1 = 4'h9,
		SRC_LB0 = 4'ha,
		SRC_LB1 = 4'hb,
		SRC_EXPOSE = 4'hc,
		SRC_FTW = 4'hd
	} cgl_src_e;

	// internal camera signals offered to the lines
	typedef struct packed {
		logic [1:0] counter_active;
		logic [1:0] logic_block;
		logic exposure_active;
		logic frame_trig_wait;
	} cgl_cam_s;

	// whole state of the block
	typedef struct packed {
		logic [1:0] sel;
		logic [3:0] dir;
		logic [3:0] inv;
		logic fkind;
		logic [3:0][SPAN_W-1:0] span_dg;
		logic [3:0][SPAN_W-1:0] span_db;
		logic [3:0][3:0] origin;
		logic [1:0] ubit;
		logic [3:0] user;
		logic [3:0] aux;
		logic [3:0] s1;
		logic [3:0] s2;
		logic [3:0] dg;
		logic [3:0][CNT_W-1:0] dg_cnt;
		logic [3:0] db;
		logic [3:0][CNT_W-1:0] db_cnt;
		logic [3:0] oe;
		logic [3:0] pout;
		logic [31:0] rdata;
	} cgl_state_s;
endpackage : cgl_pkg

// ===== cgl_line_ctrl.sv
/*
 * cgl_line_ctrl: four general-purpose lines with direction, inversion,
 * deglitch and debounce input filters, output source select and user bits.
 * assumes asynchronous line inputs, a 100 MHz clock, and an external
 * pull-up on every line since the pins are open-drain.
 */
`timescale 1ns/1ps

// Overview of operation
// R1: four lines; a line pick selects which line each per-line setting touches
// R2: per-line direction makes the picked line an input or an output
// R3: per-line polarity flip inverts that line's signal path
// R4: level read returns the picked line's present level, 1 high, 0 low
// R5: software must not treat polled levels as real-time signal observation
// R6: snapshot word holds every line level, line n in bit n
// R7: every line has its own deglitch and debounce filter, picked by kind
// R8: picked filter span on picked line is programmable in microseconds
// R9: deglitch accepts a new state only after it held the full span
// R10: debounce passes first edge at once, then ignores changes for span
// R11: deglitch output feeds the debounce stage
// R12: per-line drive origin picks the line's source, only while an output
// R13: sources are loopback, user bits, counters, logic blocks, exposure, trigger wait
// R14: trigger-wait source is high while a frame-start trigger is accepted
// R15: soft bit pick chooses a user bit; soft bit level sets it
// R16: user output word maps user output n to bit n
// R17: user output word writes and reads all user bits at once
// R18: read-only circuit type reports tri-state, opto-isolated or open-drain
// R19: open-drain lines only pull low; outside pull-up makes a high
// R20: each line may be input or output and is not isolated
// R21: inputs synchronised before filtering; spans converted to clock cycles
module cgl_line_ctrl (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [7:0] addr,
	input wire logic [31:0] wr_data,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [31:0] rd_data,
	input wire logic [3:0] line_in,
	output logic [3:0] line_out,
	output logic [3:0] line_oe,
	output logic [3:0] aux_rail_en,
	input wire cgl_pkg::cgl_cam_s cam
);

	cgl_pkg::cgl_state_s s_q;
	cgl_pkg::cgl_state_s s_d;
	logic [3:0] in_lvl;
	logic [3:0] drv;
	logic [3:0] lev;

	// span in microseconds to a whole count of clock cycles
	function automatic logic [cgl_pkg::CNT_W-1:0] span_cycles(
		input logic [cgl_pkg::SPAN_W-1:0] us
	);
		logic [cgl_pkg::CNT_W-1:0] mul;
		mul = cgl_pkg::CNT_W'(cgl_pkg::CYC_PER_US);
		return cgl_pkg::CNT_W'(us) * mul; // [R21]
	endfunction : span_cycles

	// source multiplexer for one line
	function automatic logic pick_source(
		input logic [3:0] code,
		input logic [3:0] lines,
		input logic [3:0] user,
		input cgl_pkg::cgl_cam_s c
	);
		logic v;
		v = 1'b0;
		case (cgl_pkg::cgl_src_e'(code)) // [R13]
			cgl_pkg::SRC_LINE0: v = lines[0];
			cgl_pkg::SRC_LINE1: v = lines[1];
			cgl_pkg::SRC_LINE2: v = lines[2];
			cgl_pkg::SRC_LINE3: v = lines[3];
			cgl_pkg::SRC_USER0: v = user[0];
			cgl_pkg::SRC_USER1: v = user[1];
			cgl_pkg::SRC_USER2: v = user[2];
			cgl_pkg::SRC_USER3: v = user[3];
			cgl_pkg::SRC_CTR0: v = c.counter_active[0];
			cgl_pkg::SRC_CTR1: v = c.counter_active[1];
			cgl_pkg::SRC_LB0: v = c.logic_block[0];
			cgl_pkg::SRC_LB1: v = c.logic_block[1];
			cgl_pkg::SRC_EXPOSE: v = c.exposure_active;
			cgl_pkg::SRC_FTW: v = c.frame_trig_wait; // [R14]
			default: v = 1'b0;
		endcase
		return v;
	endfunction : pick_source

	// logical levels: filtered input after polarity, or the driven value
	always_comb begin
		in_lvl = s_q.db ^ s_q.inv; // [R3]
		for (int n = 0; n < 4; n++) begin
			drv[n] = pick_source(s_q.origin[n], in_lvl, s_q.user, cam) ^ s_q.inv[n]; // [R3]
		end
		lev = (s_q.dir & drv) | (~s_q.dir & in_lvl); // [R4]
	end

	// next state: register port, filters and pin drive
	always_comb begin
		s_d = s_q;
		s_d.rdata = cgl_pkg::RD_IDLE;
		// two-flop synchroniser, first stage feeds only the second
		s_d.s1 = line_in; // [R21]
		s_d.s2 = s_q.s1;
		for (int n = 0; n < 4; n++) begin
			// deglitch: new state must hold for the full span
			if (s_q.s2[n] == s_q.dg[n]) begin
				s_d.dg_cnt[n] = '0;
			end else if (s_q.dg_cnt[n] + 1'b1 >= span_cycles(s_q.span_dg[n])) begin
				s_d.dg[n] = s_q.s2[n]; // [R9]
				s_d.dg_cnt[n] = '0;
			end else begin
				s_d.dg_cnt[n] = s_q.dg_cnt[n] + 1'b1;
			end
			// debounce on the deglitched signal: first edge passes, then lockout
			if (s_q.db_cnt[n] != '0) begin
				s_d.db_cnt[n] = s_q.db_cnt[n] - 1'b1; // [R10]
			end else if (s_q.dg[n] != s_q.db[n]) begin
				s_d.db[n] = s_q.dg[n]; // [R11]
				s_d.db_cnt[n] = span_cycles(s_q.span_db[n]); // [R10]
			end
			// open drain: enable only to pull low, and only as an output
			s_d.oe[n] = s_q.dir[n] & ~drv[n]; // [R12] [R19] [R20]
		end
		s_d.pout = '0; // [R19]
		// register writes, per-line fields go to the picked line
		if (wr_en) begin
			case (addr)
				cgl_pkg::REG_PIN_INDEX_PICK: s_d.sel = wr_data[1:0]; // [R1]
				cgl_pkg::REG_PIN_DIR: s_d.dir[s_q.sel] = wr_data[cgl_pkg::DIR_OUT_BIT]; // [R2]
				cgl_pkg::REG_PIN_POLARITY_FLIP: s_d.inv[s_q.sel] = wr_data[0]; // [R3]
				cgl_pkg::REG_PIN_FILTER_KIND_PICK: s_d.fkind = wr_data[0]; // [R7]
				cgl_pkg::REG_PIN_FILTER_SPAN_US: begin
					if (s_q.fkind == cgl_pkg::FILT_DEBOUNCE) begin
						s_d.span_db[s_q.sel] = wr_data[cgl_pkg::SPAN_W-1:0]; // [R8]
					end else begin
						s_d.span_dg[s_q.sel] = wr_data[cgl_pkg::SPAN_W-1:0]; // [R8]
					end
				end
				cgl_pkg::REG_PIN_DRIVE_ORIGIN: s_d.origin[s_q.sel] = wr_data[3:0]; // [R12]
				cgl_pkg::REG_SOFT_BIT_PICK: s_d.ubit = wr_data[1:0]; // [R15]
				cgl_pkg::REG_SOFT_BIT_LEVEL: s_d.user[s_q.ubit] = wr_data[0]; // [R15]
				cgl_pkg::REG_USER_OUTPUT_WORD: s_d.user = wr_data[3:0]; // [R16] [R17]
				cgl_pkg::REG_AUX_RAIL_SWITCH: s_d.aux[s_q.sel] = wr_data[0];
				default: s_d.sel = s_q.sel;
			endcase
		end
		// register reads, data stand in the next cycle only
		if (rd_en) begin
			case (addr)
				cgl_pkg::REG_PIN_INDEX_PICK: s_d.rdata = {30'h0, s_q.sel};
				cgl_pkg::REG_PIN_DIR: s_d.rdata = {31'h0, s_q.dir[s_q.sel]};
				cgl_pkg::REG_PIN_POLARITY_FLIP: s_d.rdata = {31'h0, s_q.inv[s_q.sel]};
				cgl_pkg::REG_PIN_LEVEL_NOW: s_d.rdata = {31'h0, lev[s_q.sel]}; // [R4]
				cgl_pkg::REG_LINE_LEVELS_SNAPSHOT: s_d.rdata = {28'h0, lev}; // [R6]
				cgl_pkg::REG_PIN_FILTER_KIND_PICK: s_d.rdata = {31'h0, s_q.fkind};
				cgl_pkg::REG_PIN_FILTER_SPAN_US: begin
					if (s_q.fkind == cgl_pkg::FILT_DEBOUNCE) begin
						s_d.rdata = {16'h0, s_q.span_db[s_q.sel]};
					end else begin
						s_d.rdata = {16'h0, s_q.span_dg[s_q.sel]};
					end
				end
				cgl_pkg::REG_PIN_DRIVE_ORIGIN: s_d.rdata = {28'h0, s_q.origin[s_q.sel]};
				cgl_pkg::REG_SOFT_BIT_PICK: s_d.rdata = {30'h0, s_q.ubit};
				cgl_pkg::REG_SOFT_BIT_LEVEL: s_d.rdata = {31'h0, s_q.user[s_q.ubit]};
				cgl_pkg::REG_USER_OUTPUT_WORD: s_d.rdata = {28'h0, s_q.user}; // [R17]
				cgl_pkg::REG_PIN_CIRCUIT_TYPE: begin
					// inputs float, outputs are open drain; never opto isolated
					s_d.rdata = {30'h0, s_q.dir[s_q.sel] ? cgl_pkg::FMT_OPEN_DRAIN
						: cgl_pkg::FMT_TRI_STATE}; // [R18] [R20]
				end
				cgl_pkg::REG_AUX_RAIL_SWITCH: s_d.rdata = {31'h0, s_q.aux[s_q.sel]};
				default: s_d.rdata = cgl_pkg::RD_IDLE;
			endcase
		end
	end

	// state register
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// outputs straight from flops
	assign rd_data = s_q.rdata;
	assign line_out = s_q.pout;
	assign line_oe = s_q.oe;
	assign aux_rail_en = s_q.aux;

	// checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	chk_input_no_drive: assert property (1'b1 |=> (line_oe & ~$past(s_q.dir)) == 4'h0) // [R2]
		else $error("input line is being driven");
	chk_od_never_high: assert property (line_out == 4'h0) // [R19]
		else $error("open drain line driven high");
	chk_pick_scope: assert property (wr_en && addr == cgl_pkg::REG_PIN_POLARITY_FLIP
		|=> ((s_q.inv ^ $past(s_q.inv)) & ~(4'h1 << $past(s_q.sel))) == 4'h0) // [R1]
		else $error("polarity write touched an unpicked line");
	chk_level_read: assert property (rd_en && addr == cgl_pkg::REG_PIN_LEVEL_NOW
		|=> rd_data == {31'h0, $past(lev[s_q.sel])}) // [R4]
		else $error("level read mismatch");
	chk_snapshot_map: assert property (rd_en && addr == cgl_pkg::REG_LINE_LEVELS_SNAPSHOT
		|=> rd_data == {28'h0, $past(lev)}) // [R6]
		else $error("snapshot word mismatch");
	chk_user_word: assert property (wr_en && addr == cgl_pkg::REG_USER_OUTPUT_WORD
		##1 rd_en && addr == cgl_pkg::REG_USER_OUTPUT_WORD
		|=> rd_data[3:0] == $past(wr_data[3:0], 2)) // [R17]
		else $error("user word not written and read as a whole");
	chk_deglitch_hold: assert property ($changed(s_q.dg[0])
		|-> s_q.dg[0] == $past(s_q.s2[0]) && $past(s_q.s2[0] != s_q.dg[0])) // [R9]
		else $error("deglitch accepted an unseen state");
	chk_debounce_lock: assert property ($changed(s_q.db[3]) && s_q.span_db[3] != '0
		|-> s_q.db_cnt[3] == span_cycles(s_q.span_db[3])) // [R10]
		else $error("debounce lockout not loaded");
	chk_debounce_follow: assert property ($changed(s_q.db[0])
		|-> s_q.db[0] == $past(s_q.dg[0])) // [R11]
		else $error("debounce not fed by deglitch");
	chk_trig_wait: assert property (s_q.dir[1] && !s_q.inv[1]
		&& s_q.origin[1] == 4'(cgl_pkg::SRC_FTW)
		|=> line_oe[1] == !$past(cam.frame_trig_wait)) // [R14]
		else $error("trigger wait not on line");

	cov_output_drive: cover property (s_q.dir[1] ##1 line_oe[1]);
	cov_debounce_edge: cover property ($changed(s_q.db[2]));
	cov_user_loop: cover property (wr_en && addr == cgl_pkg::REG_SOFT_BIT_LEVEL ##2 line_oe[0]);

endmodule : cgl_line_ctrl

// ===== cgl_ext_circuit.sv
/*
 * cgl_ext_circuit: outside circuits on the four lines.
 * assumes open-drain enables from the block; a pull-up on every line.
 */
`timescale 1ns/1ps
module cgl_ext_circuit (
	input wire logic [3:0] line_oe,
	input wire logic [3:0] ext_low,
	output logic [3:0] line_in
);
	// pull-up gives high unless someone sinks the line
	assign line_in = ~(line_oe | ext_low);
endmodule : cgl_ext_circuit

// ===== camera_gpio_line_control_tb_top.sv
/*
 * camera_gpio_line_control_tb_top: directed bench for the gpio line block.
 * assumes the register map and latencies of cgl_pkg and a pulled-up wire.
 */
`timescale 1ns/1ps
`define CHK(nm, e, a) begin checks++; if ((a) !== (e)) begin fails++; \
	$display("MISMATCH %s exp %h got %h", nm, e, a); end end
module camera_gpio_line_control_tb_top;
	logic core_clk = 0;
	logic rst = 1;
	logic [7:0] addr = 8'h00;
	logic [31:0] wr_data = 32'h0;
	logic wr_en = 0;
	logic rd_en = 0;
	logic [31:0] rd_data;
	logic [3:0] line_in, line_out, line_oe, aux_rail_en;
	logic [3:0] ext_low = 4'h0;
	cgl_pkg::cgl_cam_s cam = '0;
	int fails = 0;
	int checks = 0;
	logic [31:0] r;

	cgl_line_ctrl dut_u (.core_clk(core_clk), .rst(rst), .addr(addr), .wr_data(wr_data),
		.wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .line_in(line_in),
		.line_out(line_out), .line_oe(line_oe), .aux_rail_en(aux_rail_en), .cam(cam));
	cgl_ext_circuit ext_u (.line_oe(line_oe), .ext_low(ext_low), .line_in(line_in));

	// 100 MHz clock
	initial begin
		forever #5 core_clk = ~core_clk;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
	endtask : tick

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge core_clk);
		wr_en <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge core_clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge core_clk);
		rd_en <= 1'b0;
		#1 d = rd_data;
	endtask : rd

	task automatic end_of_test;
		if (fails == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : end_of_test

	// idle lines read high through the pull-ups
	task automatic t_reset;
		tick(10);
		rd(cgl_pkg::REG_LINE_LEVELS_SNAPSHOT, r);
		`CHK("snapshot", 32'hf, r)
		rd(cgl_pkg::REG_PIN_CIRCUIT_TYPE, r);
		`CHK("type_in", 32'(cgl_pkg::FMT_TRI_STATE), r)
		rd(8'hfc, r);
		`CHK("unmapped", 32'h0, r)
		`CHK("line_out", 4'h0, line_out)
		wr(cgl_pkg::REG_AUX_RAIL_SWITCH, 32'h1);
		tick(1);
		`CHK("aux_on", 4'h1, aux_rail_en)
		wr(cgl_pkg::REG_AUX_RAIL_SWITCH, 32'h0);
		tick(1);
		`CHK("aux_off", 4'h0, aux_rail_en)
	endtask : t_reset

	// packed word and single-bit access share the user bits
	task automatic t_user;
		wr(cgl_pkg::REG_USER_OUTPUT_WORD, 32'h5);
		rd(cgl_pkg::REG_USER_OUTPUT_WORD, r);
		`CHK("user_word", 32'h5, r)
		// back-to-back write then read of the packed word
		@(posedge core_clk);
		addr <= cgl_pkg::REG_USER_OUTPUT_WORD;
		wr_data <= 32'h9;
		wr_en <= 1'b1;
		@(posedge core_clk);
		wr_en <= 1'b0;
		rd_en <= 1'b1;
		@(posedge core_clk);
		rd_en <= 1'b0;
		#1 r = rd_data;
		`CHK("user_b2b", 32'h9, r)
		wr(cgl_pkg::REG_SOFT_BIT_PICK, 32'h3);
		wr(cgl_pkg::REG_SOFT_BIT_LEVEL, 32'h1);
		wr(cgl_pkg::REG_SOFT_BIT_PICK, 32'h0);
		wr(cgl_pkg::REG_SOFT_BIT_LEVEL, 32'h0);
		rd(cgl_pkg::REG_USER_OUTPUT_WORD, r);
		`CHK("user_bits", 32'h8, r)
	endtask : t_user

	task automatic src(input logic [3:0] code, input logic [5:0] c, input logic e);
		cam <= c;
		wr(cgl_pkg::REG_PIN_DRIVE_ORIGIN, {28'h0, code});
		tick(3);
		`CHK("oe1", e, line_oe[1])
	endtask : src

	// line 1 as an output driven from user bit 1 and camera signals
	task automatic t_drive;
		wr(cgl_pkg::REG_PIN_INDEX_PICK, 32'h1);
		wr(cgl_pkg::REG_PIN_DRIVE_ORIGIN, 32'(cgl_pkg::SRC_USER1));
		tick(3);
		`CHK("oe_in", 4'h0, line_oe)
		wr(cgl_pkg::REG_PIN_DIR, 32'h1);
		tick(3);
		`CHK("oe_out", 4'h2, line_oe)
		rd(cgl_pkg::REG_PIN_LEVEL_NOW, r);
		`CHK("level_lo", 32'h0, r)
		rd(cgl_pkg::REG_PIN_CIRCUIT_TYPE, r);
		`CHK("type_out", 32'(cgl_pkg::FMT_OPEN_DRAIN), r)
		wr(cgl_pkg::REG_PIN_POLARITY_FLIP, 32'h1);
		tick(3);
		`CHK("oe_flip", 4'h0, line_oe)
		rd(cgl_pkg::REG_PIN_LEVEL_NOW, r);
		`CHK("level_hi", 32'h1, r)
		wr(cgl_pkg::REG_PIN_POLARITY_FLIP, 32'h0);
		src(cgl_pkg::SRC_EXPOSE, 6'h00, 1'b1);
		src(cgl_pkg::SRC_EXPOSE, 6'h02, 1'b0);
		src(cgl_pkg::SRC_FTW, 6'h01, 1'b0);
		src(cgl_pkg::SRC_FTW, 6'h00, 1'b1);
		src(cgl_pkg::SRC_CTR1, 6'h20, 1'b0);
		src(cgl_pkg::SRC_LB0, 6'h00, 1'b1);
		src(cgl_pkg::SRC_LINE0, 6'h00, 1'b0);
		wr(cgl_pkg::REG_PIN_DIR, 32'h0);
	endtask : t_drive

	// deglitch of 1 us on line 2 drops a short low pulse, delays a long one
	// levels are polled only after generous settling margins
	task automatic t_deglitch;
		wr(cgl_pkg::REG_PIN_INDEX_PICK, 32'h2);
		wr(cgl_pkg::REG_PIN_FILTER_SPAN_US, 32'h1);
		ext_low <= 4'h4;
		tick(50);
		ext_low <= 4'h0;
		tick(120);
		rd(cgl_pkg::REG_LINE_LEVELS_SNAPSHOT, r);
		`CHK("glitch", 32'hf, r)
		ext_low <= 4'h4;
		tick(90);
		rd(cgl_pkg::REG_LINE_LEVELS_SNAPSHOT, r);
		`CHK("dg_wait", 32'hf, r)
		tick(30);
		rd(cgl_pkg::REG_LINE_LEVELS_SNAPSHOT, r);
		`CHK("dg_done", 32'hb, r)
		ext_low <= 4'h0;
	endtask : t_deglitch

	// debounce of 1 us on line 3: first edge at once, then locked
	task automatic t_debounce;
		wr(cgl_pkg::REG_PIN_INDEX_PICK, 32'h3);
		wr(cgl_pkg::REG_PIN_FILTER_KIND_PICK, 32'(cgl_pkg::FILT_DEBOUNCE));
		wr(cgl_pkg::REG_PIN_FILTER_SPAN_US, 32'h1);
		tick(150);
		ext_low <= 4'h8;
		tick(8);
		rd(cgl_pkg::REG_PIN_LEVEL_NOW, r);
		`CHK("db_first", 32'h0, r)
		ext_low <= 4'h0;
		tick(30);
		rd(cgl_pkg::REG_PIN_LEVEL_NOW, r);
		`CHK("db_lock", 32'h0, r)
		tick(100);
		rd(cgl_pkg::REG_PIN_LEVEL_NOW, r);
		`CHK("db_free", 32'h1, r)
	endtask : t_debounce

	// watchdog against a hung run
	initial begin
		#900us;
		fails++;
		end_of_test();
	end

	// main sequence
	initial begin
		tick(6);
		rst <= 1'b0;
		t_reset();
		t_user();
		t_drive();
		t_deglitch();
		t_debounce();
		end_of_test();
	end
endmodule : camera_gpio_line_control_tb_top
